// [stc_consts.vh]
// stc_consts.vh: constants shared by the switch trigger control block
// assumes a 200 MHz system clock; definitions only
`ifndef STC_CONSTS_VH
`define STC_CONSTS_VH

`define STC_CLK_MHZ        200
// red periods in clk cycles: 500 ms and 1000 ms at 200 MHz
`define STC_RED_A_CYC      28'd100000000
`define STC_RED_B_CYC      28'd200000000
`define STC_SAT_NS         17'd1000
`define STC_MAX_PATHS      16
`define STC_TYPE_SINGLE    2'h0
`define STC_TYPE_TOGGLE    2'h1
`define STC_TYPE_SEQ       2'h2
`define STC_TYPE_ADDR      2'h3
`define STC_LED_OFF        2'h0
`define STC_LED_GREEN      2'h1
`define STC_LED_RED        2'h2
`define STC_ERR_CMD_REFUSE 8'h01

`endif

// [stc_sync.v]
// stc_sync.v: two-flop synchroniser plus rising edge pulse
// assumes the input is asynchronous to clk
`timescale 1ns/1ps
`default_nettype none
module stc_sync (
    input  wire clk,
    input  wire arst_n,
    input  wire din,
    output reg  rise_ff
);
    reg meta_ff;
    reg sync_ff;
    reg last_ff;
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            meta_ff <= 1'b0;
            sync_ff <= 1'b0;
            last_ff <= 1'b0;
            rise_ff <= 1'b0;
        end else begin
            meta_ff <= din;
            sync_ff <= meta_ff;
            last_ff <= sync_ff;
            rise_ff <= sync_ff & ~last_ff;
        end
    end
endmodule
`default_nettype wire

// [stc_trigger.v]
// stc_trigger.v: trigger arming, path stepping and indicators
// assumes pins evt_a/evt_b asynchronous; command strobes are on clk
// assumes configuration levels settle before an arm request
// outputs are registered; strobe answers follow one clk later
`timescale 1ns/1ps
`default_nettype none
`include "stc_consts.vh"
module stc_trigger (
    input  wire        clk,
    input  wire        arst_n,
    input  wire        evt_a,
    input  wire        evt_b,
    input  wire        arm_req,
    input  wire        disarm_req,
    input  wire        manual_trig,
    input  wire        remote_trig,
    input  wire        seq_reset_req,
    input  wire        rst_cmd,
    input  wire        preset_cmd,
    input  wire        cfg_cmd,
    input  wire        manual_switch_req,
    input  wire        virt_toggle_req,
    input  wire        virt_remote_set,
    input  wire        virt_remote_val,
    input  wire        date_edit_req,
    input  wire        lock_mode,
    input  wire        ui_limit,
    input  wire        license_ok,
    input  wire        secondary_ok,
    input  wire [1:0]  trig_type,
    input  wire [4:0]  cfg_paths,
    input  wire [15:0] path_trig_ok,
    input  wire [15:0] path_on_sat,
    input  wire [15:0] base_interval_ns,
    output reg         armed_indicator_flag,
    output reg  [1:0]  led_a_ff,
    output reg  [1:0]  led_b_ff,
    output reg  [31:0] evt_count_ff,
    output reg  [3:0]  path_idx_ff,
    output reg         path_switch_ff,
    output reg         arm_fail_ff,
    output reg         err_push_ff,
    output reg  [7:0]  err_code_ff,
    output reg         cmd_exec_ff,
    output reg         manual_switch_ok_ff,
    output reg         virt_mode_ff,
    output reg         date_edit_ok_ff,
    output reg  [16:0] min_interval_ns_ff,
    output reg  [31:0] max_freq_hz_ff
);
    localparam [27:0] RED_A_CYC = `STC_RED_A_CYC;
    localparam [27:0] RED_B_CYC = `STC_RED_B_CYC;

    wire a_rise;
    wire b_rise;
    stc_sync u_sync_a (.clk(clk), .arst_n(arst_n), .din(evt_a),
                       .rise_ff(a_rise));
    stc_sync u_sync_b (.clk(clk), .arst_n(arst_n), .din(evt_b),
                       .rise_ff(b_rise));

    reg        armed_ff;
    reg        toggle_ff;
    reg        first_ff;
    reg        skip_ff;
    reg [27:0] red_a_cnt_ff;
    reg [27:0] red_b_cnt_ff;

    // enough triggerable paths for the chosen type, capped at sixteen
    reg         enough;
    reg  [4:0]  need;
    wire [15:0] path_used;
    genvar      g;
    generate
        for (g = 0; g < `STC_MAX_PATHS; g = g + 1) begin : g_path
            // entries beyond cfg_paths hold stale settings; mask them
            assign path_used[g] = (cfg_paths > g);
        end
    endgenerate
    wire all_trig = &(path_trig_ok | ~path_used);
    wire any_sat  = |(path_on_sat & path_used);

    always @* begin
        case (trig_type)
            `STC_TYPE_SINGLE: need = 5'd1;
            `STC_TYPE_TOGGLE: need = 5'd2;
            default:          need = 5'd3;
        endcase
        enough = (cfg_paths >= need) && (cfg_paths <= 5'd16);
    end

    wire complete  = enough & all_trig & secondary_ok & license_ok;
    wire blocked   = lock_mode | ui_limit | virt_mode_ff;
    wire arm_ok    = arm_req & ~armed_ff & ~blocked & complete;
    wire kill      = rst_cmd | preset_cmd;
    wire is_addr   = (trig_type == `STC_TYPE_ADDR);
    // edge and remote trigger share one path, joined by manual trigger except in addressed mode
    wire trig_evt  = armed_ff & complete &
                     (a_rise | remote_trig |
                      (manual_trig & ~is_addr));
    wire seq_rst   = armed_ff & complete &
                     (trig_type == `STC_TYPE_SEQ) &
                     (b_rise | seq_reset_req);
    // sixteen paths give cfg_paths[3:0] of zero, so the last index is 4'hf
    wire [3:0] last_idx = cfg_paths[3:0] - 4'd1;

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            armed_ff             <= 1'b0;
            armed_indicator_flag <= 1'b0;
            toggle_ff            <= 1'b0;
            first_ff             <= 1'b0;
            skip_ff              <= 1'b0;
            evt_count_ff         <= 32'h0000_0000;
            path_idx_ff          <= 4'h0;
            path_switch_ff       <= 1'b0;
            arm_fail_ff          <= 1'b0;
            err_push_ff          <= 1'b0;
            err_code_ff          <= 8'h00;
            cmd_exec_ff          <= 1'b0;
        end else begin
            path_switch_ff <= 1'b0;
            // an arm request lost to a same-cycle disarm is dropped unflagged
            arm_fail_ff    <= arm_req & ~armed_ff & ~arm_ok;
            err_push_ff    <= cfg_cmd & armed_ff;
            // the code stays until the next refusal, so a late query sees it
            err_code_ff    <= (cfg_cmd & armed_ff) ?
                              `STC_ERR_CMD_REFUSE : err_code_ff;
            cmd_exec_ff    <= cfg_cmd & ~armed_ff;
            // priority: disarm and commands, arming, reset, then events
            if (kill || disarm_req) begin
                armed_ff             <= 1'b0;
                armed_indicator_flag <= 1'b0;
            end else if (arm_ok) begin
                armed_ff             <= 1'b1;
                armed_indicator_flag <= 1'b1;
                evt_count_ff         <= 32'h0000_0000;
                path_idx_ff          <= 4'h0;
                first_ff             <= 1'b1;
                toggle_ff            <= 1'b0;
                skip_ff              <= 1'b0;
            end else if (seq_rst) begin
                path_idx_ff <= 4'h0;
                // a reset before any event makes the next event switch no path; it is still counted
                skip_ff     <= first_ff;
                first_ff    <= 1'b1;
            end else if (trig_evt) begin
                evt_count_ff <= evt_count_ff + 32'h0000_0001;
                first_ff     <= 1'b0;
                skip_ff      <= 1'b0;
                case (trig_type)
                    `STC_TYPE_SINGLE: begin
                        path_idx_ff          <= 4'h0;
                        path_switch_ff       <= 1'b1;
                        armed_ff             <= 1'b0;
                        armed_indicator_flag <= 1'b0;
                    end
                    `STC_TYPE_TOGGLE: begin
                        // toggle_ff names the path that this event selects
                        path_idx_ff    <= {3'h0, toggle_ff};
                        toggle_ff      <= ~toggle_ff;
                        path_switch_ff <= 1'b1;
                    end
                    `STC_TYPE_SEQ: begin
                        if (!skip_ff) begin
                            path_switch_ff <= 1'b1;
                            if (first_ff)
                                path_idx_ff <= 4'h0;
                            else if (path_idx_ff == last_idx)
                                path_idx_ff <= 4'h0;
                            else
                                path_idx_ff <= path_idx_ff + 4'h1;
                        end
                    end
                    default: begin
                        // addressed: events counted, address decode is outside
                        path_switch_ff <= 1'b0;
                    end
                endcase
            end
        end
    end

    // indicator timers; a fresh event restarts the red period
    // counters are 28 bits wide: one second of red is 2e8 cycles
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            red_a_cnt_ff <= 28'h0;
            red_b_cnt_ff <= 28'h0;
            led_a_ff     <= `STC_LED_OFF;
            led_b_ff     <= `STC_LED_OFF;
        end else begin
            if (!armed_ff)
                red_a_cnt_ff <= 28'h0;
            else if (trig_evt)
                red_a_cnt_ff <= RED_A_CYC;
            else if (red_a_cnt_ff != 28'h0)
                red_a_cnt_ff <= red_a_cnt_ff - 28'h1;
            if (!armed_ff)
                red_b_cnt_ff <= 28'h0;
            else if (seq_rst)
                red_b_cnt_ff <= RED_B_CYC;
            else if (red_b_cnt_ff != 28'h0)
                red_b_cnt_ff <= red_b_cnt_ff - 28'h1;
            if (!armed_ff) begin
                led_a_ff <= `STC_LED_OFF;
                led_b_ff <= `STC_LED_OFF;
            end else begin
                led_a_ff <= (red_a_cnt_ff != 28'h0) ?
                            `STC_LED_RED : `STC_LED_GREEN;
                led_b_ff <= (red_b_cnt_ff != 28'h0) ?
                            `STC_LED_RED : `STC_LED_GREEN;
            end
        end
    end

    // local gates and virtual mode; remote setting still allowed
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            virt_mode_ff        <= 1'b0;
            manual_switch_ok_ff <= 1'b0;
            date_edit_ok_ff     <= 1'b0;
        end else begin
            manual_switch_ok_ff <= manual_switch_req & ~armed_ff;
            date_edit_ok_ff     <= date_edit_req & ~armed_ff;
            if (virt_remote_set)
                virt_mode_ff <= virt_remote_val;
            else if (virt_toggle_req && !armed_ff && !lock_mode)
                virt_mode_ff <= ~virt_mode_ff;
        end
    end

    // interval reporting; the divider is iterative to save area,
    // so frequency settles up to 61 cycles after the interval changes
    wire [16:0] intv = {1'b0, base_interval_ns} +
                       (any_sat ? `STC_SAT_NS : 17'd0);
    reg  [5:0]  div_step_ff;
    reg  [29:0] rem_ff;
    reg  [29:0] quo_ff;
    reg  [16:0] dvs_ff;
    wire [29:0] trial = {rem_ff[28:0], 1'b0};
    localparam [29:0] ONE_S_NS = 30'd1000000000;
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            min_interval_ns_ff <= 17'h0;
            max_freq_hz_ff     <= 32'h0;
            div_step_ff        <= 6'h0;
            rem_ff             <= 30'h0;
            quo_ff             <= 30'h0;
            dvs_ff             <= 17'h0;
        end else begin
            min_interval_ns_ff <= intv;
            if (div_step_ff == 6'h0) begin
                dvs_ff      <= (intv == 17'h0) ? 17'h1 : intv;
                rem_ff      <= 30'h0;
                quo_ff      <= ONE_S_NS;
                div_step_ff <= 6'd30;
            end else begin
                // shift one dividend bit in per cycle
                if ((trial | {29'h0, quo_ff[29]}) >= {13'h0, dvs_ff}) begin
                    rem_ff <= (trial | {29'h0, quo_ff[29]}) -
                              {13'h0, dvs_ff};
                    quo_ff <= {quo_ff[28:0], 1'b1};
                end else begin
                    rem_ff <= trial | {29'h0, quo_ff[29]};
                    quo_ff <= {quo_ff[28:0], 1'b0};
                end
                div_step_ff <= div_step_ff - 6'h1;
                if (div_step_ff == 6'h1)
                    max_freq_hz_ff <= {2'h0, quo_ff[28:0],
                        ((trial | {29'h0, quo_ff[29]}) >=
                         {13'h0, dvs_ff})};
            end
        end
    end
endmodule
`default_nettype wire

// [stc_chk_assertions.sv]
// stc_chk_assertions.sv: concurrent checks on the trigger control block
// assumes stc_consts.vh on the include path; bound into every stc_trigger
`timescale 1ns/1ps
`default_nettype none
`include "stc_consts.vh"
module stc_chk (
    input wire logic        clk,
    input wire logic        arst_n,
    input wire logic        arm_req,
    input wire logic        disarm_req,
    input wire logic        rst_cmd,
    input wire logic        preset_cmd,
    input wire logic        cfg_cmd,
    input wire logic        manual_switch_req,
    input wire logic        lock_mode,
    input wire logic        ui_limit,
    input wire logic        armed_indicator_flag,
    input wire logic [1:0]  led_a_ff,
    input wire logic [1:0]  led_b_ff,
    input wire logic [31:0] evt_count_ff,
    input wire logic        err_push_ff,
    input wire logic        cmd_exec_ff,
    input wire logic        manual_switch_ok_ff,
    input wire logic        virt_mode_ff,
    input wire logic        arm_fail_ff
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);

    property p_arm_lock;
        arm_req && !disarm_req && !rst_cmd && !preset_cmd &&
        !armed_indicator_flag && (lock_mode || ui_limit || virt_mode_ff)
        |=> !armed_indicator_flag && arm_fail_ff;
    endproperty
    a_arm_lock: assert property (p_arm_lock)
        else $error("arming accepted while locked");
    property p_off;
        !armed_indicator_flag |=> led_a_ff == `STC_LED_OFF &&
            led_b_ff == `STC_LED_OFF;
    endproperty
    a_off: assert property (p_off)
        else $error("indicator lit while disarmed");
    property p_green;
        $rose(armed_indicator_flag) |=> led_a_ff == `STC_LED_GREEN &&
            led_b_ff == `STC_LED_GREEN;
    endproperty
    a_green: assert property (p_green)
        else $error("indicators not green after arming");
    property p_red_a;
        armed_indicator_flag && evt_count_ff == $past(evt_count_ff) + 32'h1
        |=> led_a_ff == `STC_LED_RED;
    endproperty
    a_red_a: assert property (p_red_a)
        else $error("event indicator not red after event");
    property p_clear;
        $rose(armed_indicator_flag) |-> evt_count_ff == 32'h0;
    endproperty
    a_clear: assert property (p_clear)
        else $error("event count not cleared on arming");
    property p_cfg;
        cfg_cmd && armed_indicator_flag && !rst_cmd && !preset_cmd
        |=> err_push_ff && !cmd_exec_ff;
    endproperty
    a_cfg: assert property (p_cfg)
        else $error("config command not refused while armed");
    property p_rst;
        rst_cmd || preset_cmd |=> !armed_indicator_flag;
    endproperty
    a_rst: assert property (p_rst)
        else $error("reset or preset left trigger armed");
    property p_sw;
        manual_switch_req && armed_indicator_flag |=> !manual_switch_ok_ff;
    endproperty
    a_sw: assert property (p_sw)
        else $error("manual switch granted while armed");
endmodule

bind stc_trigger stc_chk i_chk (
    .clk(clk), .arst_n(arst_n), .arm_req(arm_req), .disarm_req(disarm_req),
    .rst_cmd(rst_cmd), .preset_cmd(preset_cmd), .cfg_cmd(cfg_cmd),
    .manual_switch_req(manual_switch_req), .lock_mode(lock_mode),
    .ui_limit(ui_limit), .armed_indicator_flag(armed_indicator_flag),
    .led_a_ff(led_a_ff), .led_b_ff(led_b_ff), .evt_count_ff(evt_count_ff),
    .err_push_ff(err_push_ff), .cmd_exec_ff(cmd_exec_ff),
    .manual_switch_ok_ff(manual_switch_ok_ff), .virt_mode_ff(virt_mode_ff),
    .arm_fail_ff(arm_fail_ff)
);
`default_nettype wire

// [stc_src.sv]
// stc_src.sv: model of the external source on the two event pins
// assumes the bench calls fire(); pins idle low (pulled down) otherwise
`timescale 1ns/1ps
`default_nettype none
module stc_src (
    input  wire logic clk,
    output var logic  evt_a,
    output var logic  evt_b
);
    initial begin
        evt_a = 1'b0;
        evt_b = 1'b0;
    end
    // held four cycles so the two-flop synchroniser cannot miss it
    task automatic fire(input logic sel);
        @(posedge clk);
        if (sel)
            evt_b <= 1'b1;
        else
            evt_a <= 1'b1;
        repeat (4) @(posedge clk);
        evt_a <= 1'b0;
        evt_b <= 1'b0;
    endtask
endmodule
`default_nettype wire

// [tb.sv]
// tb.sv: self-checking bench for the switch trigger control block
// assumes stc_trigger and stc_src compiled; strobes are one-cycle pulses
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic clk, arst_n, lock, uil, lic, sec;
    logic [12:0] s;
    logic [1:0]  tt;
    logic [4:0]  np;
    logic [15:0] tok, sat, bi;
    wire logic ea, eb, fl, sw, af, ep, cx, mo, vm, dok;
    wire logic [1:0]  la, lb;
    wire logic [31:0] cnt, mf;
    wire logic [3:0]  idx;
    wire logic [7:0]  ec;
    wire logic [16:0] mi;
    int bad_count, checks, nsw;

    stc_src i_src (.clk(clk), .evt_a(ea), .evt_b(eb));
    stc_trigger i_dut (
        .clk(clk), .arst_n(arst_n), .evt_a(ea), .evt_b(eb),
        .arm_req(s[0]), .disarm_req(s[1]), .manual_trig(s[2]),
        .remote_trig(s[3]), .seq_reset_req(s[4]), .rst_cmd(s[5]),
        .preset_cmd(s[6]), .cfg_cmd(s[7]), .manual_switch_req(s[8]),
        .virt_toggle_req(s[9]), .virt_remote_set(s[10]),
        .virt_remote_val(s[12]), .date_edit_req(s[11]), .lock_mode(lock),
        .ui_limit(uil), .license_ok(lic), .secondary_ok(sec),
        .trig_type(tt), .cfg_paths(np), .path_trig_ok(tok),
        .path_on_sat(sat), .base_interval_ns(bi),
        .armed_indicator_flag(fl), .led_a_ff(la), .led_b_ff(lb),
        .evt_count_ff(cnt), .path_idx_ff(idx), .path_switch_ff(sw),
        .arm_fail_ff(af), .err_push_ff(ep), .err_code_ff(ec),
        .cmd_exec_ff(cx), .manual_switch_ok_ff(mo), .virt_mode_ff(vm),
        .date_edit_ok_ff(dok), .min_interval_ns_ff(mi),
        .max_freq_hz_ff(mf)
    );

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk) if (sw === 1'b1) nsw <= nsw + 1;

    task automatic summarize();
        $display("checks %0d, bad_count %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic ck(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: got %0h, expected %0h", $time,
                     got, exp);
        end
    endtask
    task automatic st(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // strobe mask for one cycle; registered answers are visible on return
    task automatic pu(input logic [12:0] m);
        @(posedge clk) s <= m;
        @(posedge clk) s <= 13'h0;
        #1;
    endtask
    task automatic fa();
        pu(13'h0001);
        ck(32'({fl, af}), 32'h1);
    endtask
    task automatic ar(input logic [1:0] t, input logic [4:0] n);
        @(posedge clk);
        tt <= t;
        np <= n;
        pu(13'h0001);
    endtask
    // trigger by remote command, manual request or edge on the pin
    task automatic tg(input int k, input logic [31:0] c, input logic [3:0] i);
        if (k == 0)
            pu(13'h0008);
        else if (k == 1)
            pu(13'h0004);
        else begin
            i_src.fire(1'b0);
            st(3);
        end
        ck(cnt, c);
        ck(32'(idx), 32'(i));
    endtask

    initial begin
        #50000;
        bad_count++;
        summarize();
    end
    initial begin
        {arst_n, lock, uil, s, tt, np, sat} = '0;
        {lic, sec, tok, bi} = {2'h3, 16'hffff, 16'h03e8};
        repeat (6) @(posedge clk);
        arst_n <= 1'b1;
        st(64);
        ck(32'(mi), 32'h3e8);
        ck(mf, 32'hf4240);
        ck(32'({fl, la, lb, vm}), 32'h0);
        @(posedge clk);
        lock <= 1'b1;
        tt <= 2'h2;
        np <= 5'h3;
        fa();
        pu(13'h0200);
        ck(32'(vm), 32'h0);
        @(posedge clk);
        lock <= 1'b0;
        uil <= 1'b1;
        fa();
        @(posedge clk);
        uil <= 1'b0;
        pu(13'h0200);
        ck(32'(vm), 32'h1);
        fa();
        pu(13'h0200);
        @(posedge clk);
        np <= 5'h11;
        fa();
        @(posedge clk);
        np <= 5'h2;
        fa();
        @(posedge clk);
        np <= 5'h3;
        tok <= 16'hfffb;
        fa();
        @(posedge clk);
        tok <= 16'hffff;
        sec <= 1'b0;
        fa();
        @(posedge clk);
        sec <= 1'b1;
        sat <= 16'h0004;
        pu(13'h0008);
        ck(cnt, 32'h0);
        pu(13'h0080);
        ck(32'({cx, ep}), 32'h2);
        pu(13'h0900);
        ck(32'({mo, dok}), 32'h3);
        st(64);
        ck(32'(mi), 32'h7d0);
        ck(mf, 32'h7a120);
        pu(13'h0001);
        ck(32'({fl, af}), 32'h2);
        ck(cnt, 32'h0);
        st(1);
        ck(32'({la, lb}), 32'h5);
        pu(13'h0080);
        ck(32'({cx, ep, ec}), 32'h101);
        pu(13'h0b00);
        ck(32'({mo, dok, vm}), 32'h0);
        pu(13'h1400);
        ck(32'(vm), 32'h1);
        pu(13'h0400);
        tg(0, 32'h1, 4'h0);
        st(1);
        ck(32'(la), 32'h2);
        tg(1, 32'h2, 4'h1);
        tg(2, 32'h3, 4'h2);
        tg(0, 32'h4, 4'h0);
        i_src.fire(1'b1);
        st(3);
        ck(32'(lb), 32'h2);
        tg(0, 32'h5, 4'h0);
        tg(0, 32'h6, 4'h1);
        pu(13'h0010);
        tg(0, 32'h7, 4'h0);
        pu(13'h0020);
        ck(32'(fl), 32'h0);
        pu(13'h0008);
        st(1);
        ck(32'({la, lb}), 32'h0);
        ck(nsw, 32'h7);
        pu(13'h0001);
        ck(cnt, 32'h0);
        pu(13'h0010);
        tg(0, 32'h1, 4'h0);
        st(1);
        ck(nsw, 32'h7);
        pu(13'h0040);
        ck(32'(fl), 32'h0);
        ar(2'h1, 5'h2);
        ck(cnt, 32'h0);
        tg(0, 32'h1, 4'h0);
        tg(2, 32'h2, 4'h1);
        tg(1, 32'h3, 4'h0);
        pu(13'h0002);
        ar(2'h0, 5'h1);
        tg(0, 32'h1, 4'h0);
        ck(32'(fl), 32'h0);
        ar(2'h3, 5'h3);
        pu(13'h0004);
        ck(cnt, 32'h0);
        pu(13'h0008);
        ck(cnt, 32'h1);
        pu(13'h0010);
        st(1);
        ck(32'(lb), 32'h1);
        summarize();
    end
endmodule
`default_nettype wire
